// ==== logic/strap_latch_consts.svh ====
`ifndef STRAP_LATCH_CONSTS_SVH
`define STRAP_LATCH_CONSTS_SVH

`define CLK_FREQ_HZ        25_000_000
`define BLINK_HALF_MS      50
`define BLINK_HALF_CYCLES  ((`CLK_FREQ_HZ / 1000) * `BLINK_HALF_MS)
`define BLINK_CNT_W        21
`define POR_HOLD_CYCLES    16
`define POR_CNT_W          5
`define ECAT_RST_CYCLES    16
`define PORT_MODE_W        2
`define MODE_HI_BIT        1
`define EVENT_ROUTE_W      2
`define EVENT_ROUTE_OFF    2'h0
`define EVENT_ROUTE_DEDIC  2'h1
`define EVENT_ROUTE_ERRPIN 2'h2
`define EVENT_ROUTE_GPIO   2'h3

`endif

// ==== logic/strap_latch_pkg.sv ====
package strap_latch_pkg;
  typedef enum logic [1:0] {
    PORTS2_INTERNAL,
    PORTS3_DOWNSTREAM,
    PORTS3_UPSTREAM
  } port_mode_t;

  typedef enum logic {
    LATCH_IDLE,
    LATCH_HELD
  } latch_state_t;
endpackage

// ==== logic/indicator_driver.sv ====
`include "strap_latch_consts.svh"

module indicator_driver
  import strap_latch_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic link,
  input  wire logic activity,
  input  wire logic polarityLow,
  output logic      pinOut,
  output logic      pinOe
);

  logic [`BLINK_CNT_W-1:0] blinkCnt;
  logic [`BLINK_CNT_W-1:0] next_blinkCnt;
  logic                    blinkPhase;
  logic                    next_blinkPhase;
  logic                    busy;
  logic                    next_busy;
  logic                    lit;
  logic                    next_pinOut;
  logic                    next_pinOe;

  always_comb begin
    next_blinkCnt   = blinkCnt;
    next_blinkPhase = blinkPhase;
    next_busy       = busy;
    if (!link) begin
      next_blinkCnt   = '0;
      next_blinkPhase = 1'b0;
      next_busy       = 1'b0;
    end else if (activity) begin
      // restart the half-period count on each activity; phase kept while busy
      next_blinkCnt   = '0;
      next_busy       = 1'b1;
      if (!busy) begin
        next_blinkPhase = 1'b1;
      end
    end else if (busy) begin
      if (blinkCnt == `BLINK_CNT_W'(`BLINK_HALF_CYCLES - 1)) begin
        next_blinkCnt   = '0;
        next_blinkPhase = ~blinkPhase;
        if (blinkPhase) begin
          next_busy = 1'b0;
        end
      end else begin
        next_blinkCnt = blinkCnt + 1'b1;
      end
    end
    // off no link, on idle link, toggling with traffic
    lit = link && !(busy && blinkPhase);
    // strap 0: active high open-source, 1: active low open-drain
    next_pinOut = polarityLow ? 1'b0 : 1'b1;
    next_pinOe  = ~lit;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      blinkCnt   <= '0;
      blinkPhase <= 1'b0;
      busy       <= 1'b0;
      pinOut     <= 1'b0;
      pinOe      <= 1'b1;
    end else begin
      blinkCnt   <= next_blinkCnt;
      blinkPhase <= next_blinkPhase;
      busy       <= next_busy;
      pinOut     <= next_pinOut;
      pinOe      <= next_pinOe;
    end
  end

endmodule

// ==== logic/strap_latch_led_reset_ctrl.sv ====
`include "strap_latch_consts.svh"

module strap_latch_led_reset_ctrl
  import strap_latch_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      powerOnReset,
  input  wire logic                      fieldbusResetReq,
  input  wire logic                      resetPinIn,
  output logic                           resetPinOut,
  output logic                           resetPinOe,
  input  wire logic                      portModeStrapLow,
  input  wire logic                      portModeStrapHigh,
  input  wire logic                      externalMediaTxDataBit0,
  input  wire logic                      clockInputModeStrap,
  output logic [`PORT_MODE_W-1:0]        portMode,
  output logic                           phyAAutoNegotiationDisable,
  output logic                           phyAAutomaticCrossoverDisable,
  output logic                           phyAFixed100Full,
  output logic                           clockSchmittMode,
  output logic                           strapsValid,
  input  wire logic                      port0Link,
  input  wire logic                      port0Activity,
  output logic                           port0LinkActivityIndicatorOut,
  output logic                           port0LinkActivityIndicatorOe,
  input  wire logic [3:0]                irqSources,
  input  wire logic [3:0]                irqSourceEnable,
  input  wire logic                      irqActiveHigh,
  input  wire logic                      irqPushPull,
  output logic                           irqOut,
  output logic                           irqOe,
  input  wire logic                      wakeupEvent,
  input  wire logic                      wakeupEnable,
  input  wire logic                      wakeupActiveHigh,
  input  wire logic                      wakeupPushPull,
  input  wire logic [`EVENT_ROUTE_W-1:0] wakeupRoute,
  input  wire logic                      configLoadError,
  input  wire logic                      errorIndicatorFunction,
  output logic                           wakeupEventOutput,
  output logic                           wakeupEventOutputOe,
  output logic                           errorIndicatorPin,
  output logic                           errorIndicatorPinOe,
  output logic                           gpioWakeupOut,
  output logic                           gpioWakeupOe
);

  function automatic port_mode_t decodeMode(input logic hi, input logic lo);
    if (!hi) begin
      decodeMode = PORTS2_INTERNAL;
    end else if (!lo) begin
      decodeMode = PORTS3_DOWNSTREAM;
    end else begin
      decodeMode = PORTS3_UPSTREAM;
    end
  endfunction

  // drive helper: active level in value, open-drain or push-pull
  function automatic logic [1:0] padDrive(input logic asserted, input logic activeHigh,
                                          input logic pushPull);
    logic level;
    level = asserted ? activeHigh : ~activeHigh;
    padDrive = {level, pushPull ? 1'b0 : level};
  endfunction

  latch_state_t            state;
  latch_state_t            next_state;
  logic                    pinPrev;
  logic [`POR_CNT_W-1:0]   holdCnt;
  logic [`POR_CNT_W-1:0]   next_holdCnt;
  logic                    latchNow;
  logic                    pinRelease;
  logic                    modeHi;
  logic                    modeLo;
  logic                    polStrap;
  logic                    fixedStrap;
  logic                    schmitt;
  logic                    next_modeHi;
  logic                    next_modeLo;
  logic                    next_polStrap;
  logic                    next_fixedStrap;
  logic                    next_schmitt;
  logic [1:0]              next_portMode;
  logic                    next_fixed;
  logic                    next_valid;
  logic                    next_rstOut;
  logic                    next_rstOe;
  logic [1:0]              irqDrv;
  logic [1:0]              wakeDrv;
  logic [1:0]              errDrv;
  logic                    wakeActive;
  logic                    errForced;
  port_mode_t              mode;

  assign pinRelease = resetPinIn && !pinPrev;

  always_comb begin
    next_state   = state;
    next_holdCnt = holdCnt;
    next_rstOe   = 1'b1;
    next_rstOut  = 1'b0;
    latchNow     = 1'b0;
    unique case (state)
      LATCH_IDLE: begin
        next_rstOe = 1'b0;
        if (holdCnt == `POR_CNT_W'(`POR_HOLD_CYCLES - 1)) begin
          next_state = LATCH_HELD;
          latchNow   = 1'b1;
        end else begin
          next_holdCnt = holdCnt + 1'b1;
        end
      end
      LATCH_HELD: begin
        if (powerOnReset || fieldbusResetReq) begin
          next_state   = LATCH_IDLE;
          next_holdCnt = '0;
          next_rstOe   = 1'b0;
        end else if (pinRelease) begin
          latchNow = 1'b1;
        end
      end
    endcase
    // straps frozen outside a latch event
    next_modeHi     = latchNow ? portModeStrapHigh : modeHi;
    next_modeLo     = latchNow ? portModeStrapLow : modeLo;
    mode            = decodeMode(next_modeHi, next_modeLo);
    next_polStrap   = latchNow ? portModeStrapLow : polStrap;
    // three port modes move the fixed-speed strap to the tx data pin
    next_fixedStrap = latchNow ? ((mode == PORTS2_INTERNAL) ? portModeStrapLow
                                                            : externalMediaTxDataBit0)
                               : fixedStrap;
    next_schmitt    = latchNow ? clockInputModeStrap : schmitt;
    next_portMode   = {next_modeHi, next_modeHi & next_modeLo};
    next_fixed      = next_fixedStrap;
    next_valid      = (next_state == LATCH_HELD) && resetPinIn;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state      <= LATCH_IDLE;
      holdCnt    <= '0;
      pinPrev    <= 1'b1;
      modeHi     <= 1'b0;
      modeLo     <= 1'b0;
      polStrap   <= 1'b0;
      fixedStrap <= 1'b0;
      schmitt    <= 1'b0;
      portMode   <= '0;
      phyAAutoNegotiationDisable    <= 1'b0;
      phyAAutomaticCrossoverDisable <= 1'b0;
      phyAFixed100Full              <= 1'b0;
      clockSchmittMode <= 1'b0;
      strapsValid      <= 1'b0;
      resetPinOut      <= 1'b0;
      resetPinOe       <= 1'b0;
    end else begin
      state      <= next_state;
      holdCnt    <= next_holdCnt;
      pinPrev    <= resetPinIn;
      modeHi     <= next_modeHi;
      modeLo     <= next_modeLo;
      polStrap   <= next_polStrap;
      fixedStrap <= next_fixedStrap;
      schmitt    <= next_schmitt;
      portMode   <= next_portMode;
      phyAAutoNegotiationDisable    <= next_fixed;
      phyAAutomaticCrossoverDisable <= next_fixed;
      phyAFixed100Full              <= next_fixed;
      clockSchmittMode <= next_schmitt;
      strapsValid      <= next_valid;
      resetPinOut      <= next_rstOut;
      resetPinOe       <= next_rstOe;
    end
  end

  indicator_driver u_indicator (
    .clk         (clk),
    .rst         (rst),
    .link        (port0Link && strapsValid),
    .activity    (port0Activity),
    .polarityLow (polStrap),
    .pinOut      (port0LinkActivityIndicatorOut),
    .pinOe       (port0LinkActivityIndicatorOe)
  );

  always_comb begin
    irqDrv     = padDrive(|(irqSources & irqSourceEnable), irqActiveHigh, irqPushPull);
    wakeActive = wakeupEnable && wakeupEvent;
    wakeDrv    = padDrive(wakeActive, wakeupActiveHigh, wakeupPushPull);
    errForced  = (wakeupRoute == `EVENT_ROUTE_ERRPIN) && configLoadError;
    errDrv     = padDrive(errorIndicatorFunction || errForced, 1'b1, 1'b1);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irqOut              <= 1'b0;
      irqOe               <= 1'b1;
      wakeupEventOutput   <= 1'b0;
      wakeupEventOutputOe <= 1'b1;
      errorIndicatorPin   <= 1'b0;
      errorIndicatorPinOe <= 1'b0;
      gpioWakeupOut       <= 1'b0;
      gpioWakeupOe        <= 1'b1;
    end else begin
      irqOut <= irqDrv[1];
      irqOe  <= irqDrv[0];
      wakeupEventOutput   <= wakeDrv[1];
      wakeupEventOutputOe <= (wakeupRoute == `EVENT_ROUTE_DEDIC) ? wakeDrv[0] : 1'b1;
      gpioWakeupOut       <= wakeDrv[1];
      gpioWakeupOe        <= (wakeupRoute == `EVENT_ROUTE_GPIO) ? wakeDrv[0] : 1'b1;
      if (wakeupRoute == `EVENT_ROUTE_ERRPIN) begin
        // shared pin: wakeup merged with forced error function
        errorIndicatorPin   <= wakeDrv[1] | errDrv[1];
        errorIndicatorPinOe <= 1'b0;
      end else begin
        errorIndicatorPin   <= errDrv[1];
        errorIndicatorPinOe <= 1'b0;
      end
    end
  end

endmodule

// ==== dv/strap_ctrl_sva.sv ====
module strap_ctrl_sva
  import strap_latch_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       resetPinOe,
  input wire logic [1:0] portMode,
  input wire logic       strapsValid,
  input wire logic       phyAFixed100Full,
  input wire logic       phyAAutoNegotiationDisable,
  input wire logic       phyAAutomaticCrossoverDisable,
  input wire logic       port0Link,
  input wire logic       port0LinkActivityIndicatorOe,
  input wire logic [3:0] irqSources,
  input wire logic [3:0] irqSourceEnable,
  input wire logic       irqActiveHigh,
  input wire logic       irqPushPull,
  input wire logic       irqOut,
  input wire logic       irqOe,
  input wire logic [1:0] wakeupRoute,
  input wire logic       wakeupEnable,
  input wire logic       wakeupEvent,
  input wire logic       wakeupActiveHigh,
  input wire logic       wakeupEventOutput,
  input wire logic       wakeupEventOutputOe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  reset_pin_drive_a: assert property ($fell(rst) |=> !resetPinOe [*8])
    else $error("reset pin not driven after reset");
  mode_legal_a: assert property (strapsValid |-> portMode != 2'h1)
    else $error("port mode low bit used in two port mode");
  phy_seed_a: assert property (strapsValid |->
    phyAAutoNegotiationDisable == phyAFixed100Full &&
    phyAAutomaticCrossoverDisable == phyAFixed100Full)
    else $error("phy disable defaults differ from fixed speed strap");
  straps_held_a: assert property ($past(strapsValid, 2) && strapsValid |->
    $stable(portMode) && $stable(phyAFixed100Full))
    else $error("latched straps changed without reset");
  led_off_a: assert property (strapsValid && !port0Link |=> port0LinkActivityIndicatorOe)
    else $error("indicator driven without link");
  irq_level_a: assert property (|(irqSources & irqSourceEnable) |=>
    irqOut == $past(irqActiveHigh))
    else $error("interrupt output not at active level");
  irq_drain_a: assert property (!irqPushPull |=> irqOe == irqOut)
    else $error("open drain interrupt drives high");
  wake_away_a: assert property (wakeupRoute != 2'h1 |=> wakeupEventOutputOe)
    else $error("wakeup pin driven while routed away");
  wake_level_a: assert property (wakeupRoute == 2'h1 && wakeupEnable && wakeupEvent |=>
    wakeupEventOutput == $past(wakeupActiveHigh))
    else $error("wakeup output not asserted");
  cover property (strapsValid && portMode == 2'h3);
  cover property ($rose(wakeupEventOutput));
  cover property (strapsValid && !port0LinkActivityIndicatorOe);
endmodule

// ==== dv/board_model.sv ====
module board_model (
  input  wire logic holdLow,
  input  wire logic resetPinOut,
  input  wire logic resetPinOe,
  input  wire logic port0LinkActivityIndicatorOut,
  input  wire logic port0LinkActivityIndicatorOe,
  input  wire logic ledToSupply,
  output logic      resetPinIn,
  output logic      ledLit
);
  timeunit 1ns;
  timeprecision 1ps;
  // pull-up on the reset line, low while anyone drives it low
  assign resetPinIn = !(holdLow || (!resetPinOe && !resetPinOut));
  // led to ground lights on high, led to supply lights on low
  assign ledLit = !port0LinkActivityIndicatorOe &&
                  (port0LinkActivityIndicatorOut == !ledToSupply);
endmodule

// ==== dv/tb.sv ====
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, powerOnReset, fieldbusResetReq, resetPinIn, resetPinOut, resetPinOe, holdLow;
  logic portModeStrapLow, portModeStrapHigh, externalMediaTxDataBit0, clockInputModeStrap;
  logic [1:0] portMode, wakeupRoute;
  logic [3:0] irqSources, irqSourceEnable;
  logic phyAAutoNegotiationDisable, phyAAutomaticCrossoverDisable, phyAFixed100Full;
  logic clockSchmittMode, strapsValid, port0Link, port0Activity, ledLit, ledToSupply;
  logic port0LinkActivityIndicatorOut, port0LinkActivityIndicatorOe;
  logic irqActiveHigh, irqPushPull, irqOut, irqOe, configLoadError, errorIndicatorFunction;
  logic wakeupEvent, wakeupEnable, wakeupActiveHigh, wakeupPushPull, wakeupEventOutput;
  logic wakeupEventOutputOe, errorIndicatorPin, errorIndicatorPinOe, gpioWakeupOut, gpioWakeupOe;
  logic sel;
  int n_mismatch, n_compared;
  strap_latch_led_reset_ctrl i_strap_latch_led_reset_ctrl (.*);
  board_model i_board_model (.*);
  task automatic cmp(input string what, input logic [3:0] exp, input logic [3:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wait_valid();
    int k;
    k = 0;
    tick(3);
    while (strapsValid !== 1'h1 && k < 100) begin
      tick(1);
      k++;
    end
    cmp("valid", 4'h1, {3'h0, strapsValid});
  endtask
  task automatic latch_check(input logic [1:0] how, input logic hi, lo, tx);
    @(posedge clk);
    portModeStrapHigh <= hi;
    portModeStrapLow <= lo;
    externalMediaTxDataBit0 <= tx;
    holdLow <= how == 2'h0;
    fieldbusResetReq <= how == 2'h1;
    powerOnReset <= how == 2'h2;
    tick(4);
    cmp("pinOe", {3'h0, how == 2'h0}, {3'h0, resetPinOe});
    @(posedge clk);
    holdLow <= 1'h0;
    fieldbusResetReq <= 1'h0;
    powerOnReset <= 1'h0;
    wait_valid();
    cmp("mode", {2'h0, hi, hi & lo}, {2'h0, portMode});
    cmp("phyA", {1'h0, {3{hi ? tx : lo}}}, {1'h0, phyAAutoNegotiationDisable,
        phyAAutomaticCrossoverDisable, phyAFixed100Full});
    @(posedge clk);
    portModeStrapHigh <= !hi;
    externalMediaTxDataBit0 <= !tx;
    tick(5);
    cmp("held", {1'h0, hi, hi & lo, hi ? tx : lo},
        {1'h0, portMode, phyAFixed100Full});
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    wrap_up();
  end
  initial begin
    {rst, clockInputModeStrap, portModeStrapLow, ledToSupply} = 4'hF;
    {powerOnReset, fieldbusResetReq, holdLow, portModeStrapHigh, externalMediaTxDataBit0} = 5'h00;
    {port0Link, port0Activity, irqActiveHigh, irqPushPull, configLoadError} = 5'h00;
    {wakeupEvent, wakeupEnable, wakeupActiveHigh, wakeupPushPull, errorIndicatorFunction} = 5'h00;
    {irqSources, irqSourceEnable, wakeupRoute} = 10'h000;
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    tick(3);
    cmp("porDrive", 4'h0, {1'h0, resetPinIn, resetPinOut, resetPinOe});
    wait_valid();
    cmp("schmitt", 4'h1, {3'h0, clockSchmittMode});
    cmp("phyA", 4'h7, {1'h0, phyAAutoNegotiationDisable, phyAAutomaticCrossoverDisable,
        phyAFixed100Full});
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      port0Link <= i[0];
      port0Activity <= i[1];
      tick(1);
      @(posedge clk);
      port0Activity <= 1'h0;
      tick(3);
      // active low led: pin low, driven, lit
      if (i == 1) cmp("ledOn", 4'h4, {1'h0, ledLit, port0LinkActivityIndicatorOe,
          port0LinkActivityIndicatorOut});
      else if (!i[0]) cmp("ledOff", 4'h1, {2'h0, ledLit, port0LinkActivityIndicatorOe});
      else cmp("ledBlink", 4'h1,
          {2'h0, ledLit, port0LinkActivityIndicatorOe});
    end
    // last pass latches an active high polarity strap for the led-to-ground check
    for (int m = 0; m < 12; m++) latch_check(2'(m / 4), m[1], !m[0], m[0]);
    ledToSupply = 1'h0;
    @(posedge clk);
    port0Link <= 1'h1;
    tick(3);
    cmp("ledHigh", 4'h5, {1'h0, ledLit, port0LinkActivityIndicatorOe,
        port0LinkActivityIndicatorOut});
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      {irqActiveHigh, irqPushPull} <= 2'(i);
      irqSources <= 4'h5;
      irqSourceEnable <= i[2] ? 4'h2 : 4'h4;
      tick(3);
      cmp("irq", {2'h0, i[1] ^ i[2], i[0] ? 1'h0 : i[1] ^ i[2]}, {2'h0, irqOut, irqOe});
    end
    for (int r = 0; r < 5; r++) begin
      @(posedge clk);
      {wakeupEnable, wakeupEvent, wakeupActiveHigh, wakeupPushPull} <= {r != 4, 3'h7};
      wakeupRoute <= r == 4 ? 2'h1 : 2'(r);
      tick(3);
      sel = r == 2 ? errorIndicatorPin : r == 3 ? gpioWakeupOut : r == 0 ? 1'h0 : wakeupEventOutput;
      cmp("wake", {1'h0, r != 1 && r != 4, r != 3, r != 0 && r != 4},
          {1'h0, wakeupEventOutputOe, gpioWakeupOe, sel});
    end
    @(posedge clk);
    wakeupRoute <= 2'h2;
    configLoadError <= 1'h1;
    tick(3);
    cmp("errForced", 4'h2, {2'h0, errorIndicatorPin, errorIndicatorPinOe});
    wrap_up();
  end
endmodule
bind strap_latch_led_reset_ctrl strap_ctrl_sva i_strap_ctrl_sva (.*);
